// ===== cmpirq_map.svh
`ifndef CMPIRQ_MAP_SVH
`define CMPIRQ_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the bus
// ----------------------------------------------------------------------------
`define CMPIRQ_OFS_STATUS      8'h00
`define CMPIRQ_OFS_CONTROL     8'h04
`define CMPIRQ_OFS_IRQ_STAT    8'h08
`define CMPIRQ_OFS_IRQ_CLEAR   8'h0C
`define CMPIRQ_OFS_IRQ_ENABLE  8'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CMPIRQ_STAT_LEVEL_LSB  0
`define CMPIRQ_STAT_FLAG_LSB   4
`define CMPIRQ_CTRL_ENABLE     0
`define CMPIRQ_CTRL_CHEN_LSB   1
`define CMPIRQ_CTRL_POL_CH0    5
`define CMPIRQ_CTRL_POL_CH1    6
`define CMPIRQ_CTRL_POL_CH23   7

// ----------------------------------------------------------------------------
// Reset values and interrupt routing
// ----------------------------------------------------------------------------
`define CMPIRQ_RST_CONTROL     8'h00
`define CMPIRQ_RST_FLAGS       4'h0
`define CMPIRQ_IRQ_MAP_BIT     2

`endif

// ===== cmpirq_pkg.sv
package cmpirq_pkg;

	// Number of comparator channels.
	localparam int CMPIRQ_CHANNELS = 4;

	// One bit per comparator channel.
	typedef logic [CMPIRQ_CHANNELS-1:0] cmpirq_chan_t;

	// Eight-bit register contents.
	typedef logic [7:0] cmpirq_reg_t;

	// Decoded register selection.
	typedef enum {
		CMPIRQ_SEL_STATUS,
		CMPIRQ_SEL_CONTROL,
		CMPIRQ_SEL_IRQ_STAT,
		CMPIRQ_SEL_IRQ_CLEAR,
		CMPIRQ_SEL_IRQ_ENABLE,
		CMPIRQ_SEL_NONE
	} cmpirq_sel_t;

endpackage

// ===== cmpirq_chan_sync.sv
`timescale 1ns/100ps

module cmpirq_chan_sync
(
	// Clock and reset.
	input  wire logic clock_in,
	input  wire logic rstn_in,
	// Raw comparator output.
	input  wire logic raw_in,
	// Synchronised level and single-cycle edge pulses.
	output logic      level_out,
	output logic      rise_out,
	output logic      fall_out
);

	logic meta_q;
	logic sync_q;
	logic prev_q;

	// Two flip-flops bring the analog result into the clock domain.
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end
		else
		begin
			meta_q <= raw_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// Edges come from the settled stage only, so each edge pulses once.
	assign level_out = sync_q;
	assign rise_out  = sync_q & ~prev_q;
	assign fall_out  = ~sync_q & prev_q;

endmodule // cmpirq_chan_sync

// ===== cmpirq_irq_ctrl.sv
`timescale 1ns/100ps

module cmpirq_irq_ctrl
(
	// Clock and reset.
	input  wire logic                 clock_in,
	input  wire logic                 rstn_in,
	// Event pulses and software controls.
	input  wire cmpirq_pkg::cmpirq_chan_t event_in,
	input  wire cmpirq_pkg::cmpirq_chan_t clear_in,
	input  wire logic                 enable_we_in,
	input  wire cmpirq_pkg::cmpirq_chan_t enable_data_in,
	// Status, mask and interrupt line.
	output cmpirq_pkg::cmpirq_chan_t  status_out,
	output cmpirq_pkg::cmpirq_chan_t  enable_out,
	output logic                      irq_out
);
	import cmpirq_pkg::*;

	cmpirq_chan_t status_q;
	cmpirq_chan_t status_d;
	cmpirq_chan_t enable_q;
	logic         irq_q;

	// A new event wins over a clear in the same cycle.
	assign status_d = (status_q & ~clear_in) | event_in;

	// Sticky status bits.
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
			status_q <= '0;
		else
			status_q <= status_d;
	end

	// Interrupt enable mask.
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
			enable_q <= '0;
		else if (enable_we_in)
			enable_q <= enable_data_in;
	end

	// All channels merge into one registered level line.
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
			irq_q <= 1'b0;
		else
			irq_q <= |(status_d & enable_q);
	end

	assign status_out = status_q;
	assign enable_out = enable_q;
	assign irq_out    = irq_q;

endmodule // cmpirq_irq_ctrl

// ===== cmpirq_top.sv
`timescale 1ns/100ps
`include "cmpirq_map.svh"

// Summary of operation
// R1 - A qualifying channel edge sets its sticky flag, status bits 7..4; reading status clears them.
// R2 - Status bits 3..0 return the synchronised comparator levels while control bit 0 is 1, and zero while it is 0.
// R3 - Control bit 7 at 1 makes channels 2 and 3 interrupt on rising edges.
// R4 - Control bit 7 at 0 makes channels 2 and 3 interrupt on falling edges.
// R5 - Control bit 6 picks rising (1) or falling (0) edges for channel 1.
// R6 - Control bit 5 picks rising (1) or falling (0) edges for channel 0.
// R7 - A channel interrupts only when its enable, control bits 4..1, is set.
// R8 - Control bit 0 switches the comparator block on or off.
// R9 - Reset clears every control and status bit to zero.
// R10 - The combined request goes by default to upper request register bit 2.
// R11 - All four channels merge into a single interrupt output line.
// R12 - The block draws no current while switched off by its enable bit.
// R13 - Software sets edges and enable before enabling channel interrupts.
// R14 - Each comparator output is synchronised so each edge gives exactly one event.
module cmpirq_top
#(
	parameter int IRQ_MAP_BIT = `CMPIRQ_IRQ_MAP_BIT
)
(
	// Clock and reset.
	input  wire logic                     clock_in,
	input  wire logic                     rstn_in,
	// Wishbone slave.
	input  wire logic                     wb_cyc_in,
	input  wire logic                     wb_stb_in,
	input  wire logic                     wb_we_in,
	input  wire logic [7:0]               wb_adr_in,
	input  wire logic [3:0]               wb_sel_in,
	input  wire logic [31:0]              wb_dat_in,
	output logic      [31:0]              wb_dat_out,
	output logic                          wb_ack_out,
	// Analog comparator side.
	input  wire cmpirq_pkg::cmpirq_chan_t comparator_levels_in,
	output logic                          comparator_power_out,
	// Interrupt towards the interrupt manager.
	output logic                          irq_out
);
	import cmpirq_pkg::*;

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	cmpirq_reg_t  control_q;
	cmpirq_chan_t flags_q;
	cmpirq_chan_t flags_d;
	logic         ack_q;
	logic [31:0]  dat_q;
	logic         power_q;
	cmpirq_chan_t level_s;
	cmpirq_chan_t rise_s;
	cmpirq_chan_t fall_s;
	cmpirq_chan_t polarity;
	cmpirq_chan_t chan_en;
	cmpirq_chan_t events;
	cmpirq_chan_t levels_vis;
	cmpirq_chan_t irq_clear;
	cmpirq_chan_t irq_stat;
	cmpirq_chan_t irq_en;
	logic         irq_line;
	logic         req;
	logic         take;
	logic         wr_take;
	logic         rd_take;
	logic         block_on;
	cmpirq_sel_t  sel;
	cmpirq_reg_t  rd_byte;

	// ------------------------------------------------------------------------
	// Comparator synchronisers
	// ------------------------------------------------------------------------

	// One synchroniser and edge detector per channel.
	for (genvar ch = 0; ch < CMPIRQ_CHANNELS; ch++)
	begin : g_chan
		cmpirq_chan_sync u_sync
		(
			.clock_in  (clock_in),
			.rstn_in   (rstn_in),
			.raw_in    (comparator_levels_in[ch]),
			.level_out (level_s[ch]),
			.rise_out  (rise_s[ch]),
			.fall_out  (fall_s[ch])
		); // [R14]
	end

	// ------------------------------------------------------------------------
	// Event qualification
	// ------------------------------------------------------------------------

	// Edge polarity per channel; channels 2 and 3 share one selector.
	assign block_on    = control_q[`CMPIRQ_CTRL_ENABLE];
	assign polarity[0] = control_q[`CMPIRQ_CTRL_POL_CH0];  // [R6]
	assign polarity[1] = control_q[`CMPIRQ_CTRL_POL_CH1];  // [R5]
	assign polarity[2] = control_q[`CMPIRQ_CTRL_POL_CH23]; // [R3] [R4]
	assign polarity[3] = control_q[`CMPIRQ_CTRL_POL_CH23]; // [R3] [R4]
	assign chan_en     = control_q[`CMPIRQ_CTRL_CHEN_LSB +: CMPIRQ_CHANNELS];

	// An event needs the block on, the channel enabled and the chosen edge.
	assign events = {CMPIRQ_CHANNELS{block_on}} & chan_en
		& ((polarity & rise_s) | (~polarity & fall_s)); // [R7] [R8]

	// An unpowered comparator has no valid output, so its level reads zero.
	assign levels_vis = level_s & {CMPIRQ_CHANNELS{block_on}};

	// ------------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------------

	// A request is taken once, in the cycle before the acknowledge.
	assign req     = wb_cyc_in & wb_stb_in;
	assign take    = req & ~ack_q;
	assign wr_take = take & wb_we_in & wb_sel_in[0];
	assign rd_take = take & ~wb_we_in;

	// Address decode to a register selection.
	always_comb
	begin
		unique case (wb_adr_in)
			`CMPIRQ_OFS_STATUS:     sel = CMPIRQ_SEL_STATUS;
			`CMPIRQ_OFS_CONTROL:    sel = CMPIRQ_SEL_CONTROL;
			`CMPIRQ_OFS_IRQ_STAT:   sel = CMPIRQ_SEL_IRQ_STAT;
			`CMPIRQ_OFS_IRQ_CLEAR:  sel = CMPIRQ_SEL_IRQ_CLEAR;
			`CMPIRQ_OFS_IRQ_ENABLE: sel = CMPIRQ_SEL_IRQ_ENABLE;
			default:                sel = CMPIRQ_SEL_NONE;
		endcase
	end

	// Read multiplexer; unmapped and write-only registers read zero.
	always_comb
	begin
		unique case (sel)
			CMPIRQ_SEL_STATUS:     rd_byte = {flags_q, levels_vis}; // [R2]
			CMPIRQ_SEL_CONTROL:    rd_byte = control_q;
			CMPIRQ_SEL_IRQ_STAT:   rd_byte = {4'h0, irq_stat};
			CMPIRQ_SEL_IRQ_ENABLE: rd_byte = {4'h0, irq_en};
			default:               rd_byte = 8'h00;
		endcase
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------

	// Control register, written through byte lane 0.
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
			control_q <= `CMPIRQ_RST_CONTROL; // [R9]
		else if (wr_take && sel == CMPIRQ_SEL_CONTROL)
			control_q <= wb_dat_in[7:0];
	end

	// Event flags clear on a status read; a same-cycle event survives.
	assign flags_d = ((rd_take && sel == CMPIRQ_SEL_STATUS) ? `CMPIRQ_RST_FLAGS : flags_q)
		| events; // [R1]

	// Sticky per-channel event flags.
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
			flags_q <= `CMPIRQ_RST_FLAGS; // [R9]
		else
			flags_q <= flags_d; // [R1]
	end

	// Single-cycle acknowledge with registered read data.
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
		begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= take;
			dat_q <= rd_take ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	// Analog supply enable; the comparators are unpowered when off.
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
			power_q <= 1'b0;
		else
			power_q <= control_q[`CMPIRQ_CTRL_ENABLE]; // [R8] [R12]
	end

	// ------------------------------------------------------------------------
	// Interrupt status, clear and enable
	// ------------------------------------------------------------------------

	// Write-only clear register, one-cycle strobe per bit.
	assign irq_clear = (wr_take && sel == CMPIRQ_SEL_IRQ_CLEAR) ? wb_dat_in[3:0] : 4'h0;

	// Sticky interrupt status gated by its mask onto one line.
	cmpirq_irq_ctrl u_irq
	(
		.clock_in       (clock_in),
		.rstn_in        (rstn_in),
		.event_in       (events),
		.clear_in       (irq_clear),
		.enable_we_in   (wr_take && sel == CMPIRQ_SEL_IRQ_ENABLE),
		.enable_data_in (wb_dat_in[3:0]),
		.status_out     (irq_stat),
		.enable_out     (irq_en),
		.irq_out        (irq_line)
	); // [R11]

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------

	// Line feeds upper request bit MAP_BIT in the interrupt manager; IRQ_MAP_BIT is not used.
	assign irq_out              = irq_line; // [R10] [R11]
	assign wb_ack_out           = ack_q;
	assign wb_dat_out           = dat_q;
	assign comparator_power_out = power_q;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rstn_in);

	flag_set_a: assert property (events != 4'h0 |=> (flags_q & $past(events)) == $past(events)) // [R1]
		else $error("Event did not set its sticky flag.");

	flag_clear_a: assert property ((rd_take && sel == CMPIRQ_SEL_STATUS && events == 4'h0) // [R1]
		|=> flags_q == 4'h0)
		else $error("Status read did not clear the event flags.");

	level_read_a: assert property ((rd_take && sel == CMPIRQ_SEL_STATUS) // [R2]
		|=> wb_ack_out && wb_dat_out[3:0] == $past(levels_vis))
		else $error("Status read returned stale comparator levels.");

	pol_rise_a: assert property ((events[2] || events[3]) && control_q[7] // [R3]
		|-> (events[3:2] & ~rise_s[3:2]) == 2'b00)
		else $error("Channel 2 or 3 fired without a rising edge.");

	pol_fall_a: assert property ((events[2] || events[3]) && !control_q[7] // [R4]
		|-> (events[3:2] & ~fall_s[3:2]) == 2'b00)
		else $error("Channel 2 or 3 fired without a falling edge.");

	ch1_edge_a: assert property (events[1] |-> (control_q[6] ? rise_s[1] : fall_s[1])) // [R5]
		else $error("Channel 1 fired on the wrong edge.");

	ch0_edge_a: assert property (events[0] |-> (control_q[5] ? rise_s[0] : fall_s[0])) // [R6]
		else $error("Channel 0 fired on the wrong edge.");

	chan_gate_a: assert property ((events & ~control_q[4:1]) == 4'h0) // [R7]
		else $error("Disabled channel produced an event.");

	block_off_a: assert property (!control_q[0] |-> events == 4'h0 ##1 !comparator_power_out) // [R8] [R12]
		else $error("Switched-off block produced an event or stayed powered.");

	reset_clear_a: assert property (@(posedge clock_in) disable iff (1'b0)
		!rstn_in |=> control_q == 8'h00 && flags_q == 4'h0 && !irq_out) // [R9]
		else $error("Reset left a control or status bit set.");

	irq_merge_a: assert property ($stable(irq_en) |-> irq_out == |(irq_stat & irq_en)) // [R11]
		else $error("Interrupt line does not follow enabled status.");

	edge_once_a: assert property (rise_s != 4'h0 |=> (rise_s & $past(rise_s)) == 4'h0) // [R14]
		else $error("One edge produced more than one pulse.");

	// Edge, flag, interrupt, control, supply and level checks that the tests seldom reach directly.
	fall_once_a: assert property (fall_s != 4'h0 |=> (fall_s & $past(fall_s)) == 4'h0) // [R14]
		else $error("One falling edge produced more than one pulse.");

	flag_hold_a: assert property (!(rd_take && sel == CMPIRQ_SEL_STATUS) && events == 4'h0 // [R1]
		|=> $stable(flags_q))
		else $error("Event flags changed without an event or a status read.");

	irq_set_a: assert property (events != 4'h0 // [R11]
		|=> (irq_stat & $past(events)) == $past(events))
		else $error("Event did not set its interrupt status bit.");

	irq_quiet_a: assert property (irq_en == 4'h0 |=> !irq_out) // [R11]
		else $error("Interrupt line rose with every channel masked.");

	ctrl_write_a: assert property ((wr_take && sel == CMPIRQ_SEL_CONTROL) // [R8]
		|=> control_q == 8'($past(wb_dat_in)))
		else $error("Control write did not land.");

	ctrl_hold_a: assert property (!(wr_take && sel == CMPIRQ_SEL_CONTROL) |=> $stable(control_q)) // [R8]
		else $error("Control register changed without a write.");

	power_follow_a: assert property (comparator_power_out == $past(block_on)) // [R8] [R12]
		else $error("Supply enable does not follow the block enable bit.");

	level_off_a: assert property ((rd_take && sel == CMPIRQ_SEL_STATUS && !block_on) // [R2] [R8]
		|=> wb_dat_out[3:0] == 4'h0)
		else $error("Switched-off block returned comparator levels.");

endmodule // cmpirq_top

// ===== cmpirq_mgr_model.sv
`timescale 1ns/100ps

module cmpirq_mgr_model
#(
	parameter int MAP_BIT = 2
)
(
	// Clock and reset.
	input  wire logic        clock_in,
	input  wire logic        rstn_in,
	// Combined request and the upper request register.
	input  wire logic        irq_in,
	output logic      [7:0]  request_out
);
	// The single request line lands in its mapped bit of the upper register.
	always_ff @(posedge clock_in)
	begin
		if (!rstn_in)
			request_out <= 8'h00;
		else
			request_out <= 8'(irq_in) << MAP_BIT;
	end
endmodule // cmpirq_mgr_model

// ===== cmpirq_tb_top.sv
`timescale 1ns/100ps
`include "cmpirq_map.svh"

module cmpirq_tb_top;
	import cmpirq_pkg::*;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic         clock, rstn, cyc, stb, we, ack, power, irq;
	logic [7:0]   adr, mgr_req;
	logic [3:0]   sel;
	logic [31:0]  dat_w, dat_r, rd;
	cmpirq_chan_t levels;
	int           err_count, cmp_count;

	// Free running 5 ns clock.
	initial clock = 1'b0;
	always #2.5 clock = ~clock;

	// Block under test and interrupt manager model.
	cmpirq_top dut_u (.clock_in(clock), .rstn_in(rstn), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
		.wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat_w), .wb_dat_out(dat_r), .wb_ack_out(ack),
		.comparator_levels_in(levels), .comparator_power_out(power), .irq_out(irq));
	cmpirq_mgr_model mgr_u (.clock_in(clock), .rstn_in(rstn), .irq_in(irq), .request_out(mgr_req));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
			err_count++;
		end
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge clock);
	endtask

	// One classic cycle; holds the request until ack is sampled high.
	task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		int n;
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat_w <= d;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (ack !== 1'b1);
		rd = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		check("bus ack", n, 32'h2);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, 4'hF, {24'h0, d});
	endtask

	task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 4'hF, 32'h0);
		check(name, rd, {24'h0, exp});
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic reset_values();
		rdchk("control", `CMPIRQ_OFS_CONTROL, 8'h00);
		rdchk("status", `CMPIRQ_OFS_STATUS, 8'h00);
		rdchk("irq enable", `CMPIRQ_OFS_IRQ_ENABLE, 8'h00);
		rdchk("irq status", `CMPIRQ_OFS_IRQ_STAT, 8'h00);
		check("irq reset", {31'h0, irq}, 32'h0);
		check("power", {31'h0, power}, 32'h0);
	endtask

	task automatic bus_refusals();
		levels <= 4'h5;
		wr(`CMPIRQ_OFS_CONTROL, 8'hA5);
		rdchk("control rw", `CMPIRQ_OFS_CONTROL, 8'hA5);
		bus(1'b1, `CMPIRQ_OFS_CONTROL, 4'hE, 32'hFF);
		rdchk("control sel", `CMPIRQ_OFS_CONTROL, 8'hA5);
		bus(1'b0, `CMPIRQ_OFS_STATUS, 4'hF, 32'h0);
		wr(`CMPIRQ_OFS_STATUS, 8'hFF);
		rdchk("status ro", `CMPIRQ_OFS_STATUS, 8'h05);
		wr(8'h20, 8'h5A);
		rdchk("unmapped", 8'h20, 8'h00);
		rdchk("irq clear wo", `CMPIRQ_OFS_IRQ_CLEAR, 8'h00);
	endtask

	// Edges and block enable go in first, channel enables after.
	task automatic edge_case(input logic [7:0] ctrl, input cmpirq_chan_t from, to, input logic [7:0] exp);
		levels <= from;
		wr(`CMPIRQ_OFS_CONTROL, ctrl & 8'hE1);
		wr(`CMPIRQ_OFS_CONTROL, ctrl);
		ticks(5);
		bus(1'b0, `CMPIRQ_OFS_STATUS, 4'hF, 32'h0);
		levels <= to;
		ticks(5);
		rdchk("status edge", `CMPIRQ_OFS_STATUS, exp);
		check("power", {31'h0, power}, {31'h0, ctrl[0]});
	endtask

	task automatic polarity();
		edge_case(8'hFF, 4'h0, 4'hF, 8'hFF);
		edge_case(8'h1F, 4'hF, 4'h0, 8'hF0);
		edge_case(8'hFF, 4'hF, 4'h0, 8'h00);
		edge_case(8'hC5, 4'h0, 4'hF, 8'h2F);
		edge_case(8'h89, 4'h0, 4'hF, 8'h4F);
		edge_case(8'h3F, 4'h0, 4'hF, 8'h1F);
		edge_case(8'hFE, 4'h0, 4'hF, 8'h00);
	endtask

	task automatic irq_path();
		levels <= 4'h0;
		wr(`CMPIRQ_OFS_CONTROL, 8'h21);
		wr(`CMPIRQ_OFS_CONTROL, 8'h23);
		wr(`CMPIRQ_OFS_IRQ_ENABLE, 8'h01);
		ticks(5);
		bus(1'b0, `CMPIRQ_OFS_STATUS, 4'hF, 32'h0);
		wr(`CMPIRQ_OFS_IRQ_CLEAR, 8'h0F);
		ticks(2);
		check("irq idle", {31'h0, irq}, 32'h0);
		levels <= 4'h1;
		ticks(5);
		check("irq set", {31'h0, irq}, 32'h1);
		check("mgr bit", {24'h0, mgr_req}, 32'h4);
		rdchk("irq status", `CMPIRQ_OFS_IRQ_STAT, 8'h01);
		rdchk("status event", `CMPIRQ_OFS_STATUS, 8'h11);
		rdchk("status cleared", `CMPIRQ_OFS_STATUS, 8'h01);
		wr(`CMPIRQ_OFS_IRQ_ENABLE, 8'h00);
		ticks(2);
		check("irq masked", {31'h0, irq}, 32'h0);
		wr(`CMPIRQ_OFS_IRQ_ENABLE, 8'h01);
		ticks(2);
		check("irq unmasked", {31'h0, irq}, 32'h1);
		wr(`CMPIRQ_OFS_IRQ_CLEAR, 8'h01);
		ticks(2);
		check("irq cleared", {31'h0, irq}, 32'h0);
	endtask

	task automatic mid_reset();
		wr(`CMPIRQ_OFS_CONTROL, 8'hFF);
		levels <= 4'hF;
		ticks(5);
		rstn <= 1'b0;
		ticks(4);
		check("power in reset", {31'h0, power}, 32'h0);
		rstn <= 1'b1;
		ticks(1);
		rdchk("control", `CMPIRQ_OFS_CONTROL, 8'h00);
		rdchk("irq enable", `CMPIRQ_OFS_IRQ_ENABLE, 8'h00);
		rdchk("flags reset", `CMPIRQ_OFS_STATUS, 8'h00);
		rdchk("irq status reset", `CMPIRQ_OFS_IRQ_STAT, 8'h00);
	endtask

	// ------------------------------------------------------------------
	// Sequence, verdict and watchdog
	// ------------------------------------------------------------------
	task automatic finish_test();
		$display("Comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Main sequence after a four cycle reset.
	initial
	begin
		{cyc, stb, we, adr, sel, dat_w, levels} = '0;
		rstn = 1'b0;
		ticks(4);
		rstn <= 1'b1;
		ticks(1);
		reset_values();
		bus_refusals();
		polarity();
		irq_path();
		mid_reset();
		finish_test();
	end

	// Cuts a hang short well beyond the expected run length.
	initial
	begin
		ticks(20000);
		err_count++;
		finish_test();
	end
endmodule // cmpirq_tb_top
